// file: grm_pkg.sv
package grm_pkg;

  // Register byte offsets
  localparam logic [7:0]  GRM_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  GRM_MASK_OFS   = 8'h04;
  localparam logic [7:0]  GRM_CMP_OFS    = 8'h08;
  localparam logic [7:0]  GRM_ADDR_OFS   = 8'h0C;
  localparam logic [7:0]  GRM_DATA_OFS   = 8'h10;
  localparam logic [7:0]  GRM_STAT_OFS   = 8'h14;
  localparam logic [7:0]  GRM_LATCH_OFS  = 8'h18;

  // Control field positions
  localparam int          GRM_CTRL_INC   = 0;
  localparam int          GRM_CTRL_VERT  = 1;
  localparam int          GRM_CTRL_OP    = 2;
  localparam int          GRM_CTRL_WIDE  = 5;

  // Values after reset
  localparam logic        GRM_INC_RST    = 1'b1;
  localparam logic [15:0] GRM_MASK_RST   = 16'h0000;
  localparam logic [15:0] GRM_CMP_RST    = 16'h0000;
  localparam logic [15:0] GRM_ADDR_RST   = 16'h0000;

  // Display geometry: row in the high byte, column in the low byte
  localparam logic [7:0]  GRM_ROW_LAST   = 8'hAF;
  localparam logic [7:0]  GRM_COL_LAST   = 8'h83;
  localparam int          GRM_FIFO_DEPTH = 4;

  typedef enum logic [2:0] {
    GRM_OP_REPLACE     = 3'b000,
    GRM_OP_OR          = 3'b001,
    GRM_OP_AND         = 3'b010,
    GRM_OP_XOR         = 3'b011,
    GRM_OP_RD_MATCH    = 3'b100,
    GRM_OP_RD_MISMATCH = 3'b101,
    GRM_OP_WR_MATCH    = 3'b110,
    GRM_OP_WR_MISMATCH = 3'b111
  } grm_op_type;

  typedef enum logic [1:0] {
    GRM_ST_IDLE  = 2'b00,
    GRM_ST_READ  = 2'b01,
    GRM_ST_WRITE = 2'b10
  } grm_state_type;

endpackage : grm_pkg

// file: grm_display_ram_rmw.sv
`timescale 1ns/1ns

module grm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
  } grm_fifo_state_type;

  grm_fifo_state_type state_reg;
  grm_fifo_state_type state_next;
  logic [WIDTH-1:0]   mem [0:DEPTH-1];
  logic               push;
  logic               pop;

  function automatic logic [PW-1:0] grm_ptr_step(input logic [PW-1:0] p);
    grm_ptr_step = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : grm_ptr_step

  assign in_ready  = (state_reg.count != CW'(DEPTH));
  assign out_valid = (state_reg.count != '0);
  assign out_data  = mem[state_reg.rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.wptr = grm_ptr_step(state_reg.wptr);
    end
    if (pop) begin
      state_next.rptr = grm_ptr_step(state_reg.rptr);
    end
    if (push && !pop) begin
      state_next.count = state_reg.count + CW'(1);
    end else if (pop && !push) begin
      state_next.count = state_reg.count - CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[state_reg.wptr] <= in_data;
    end
  end

endmodule : grm_fifo

module grm_display_ram_rmw
  import grm_pkg::*;
#(
  parameter logic [7:0] ROW_LAST   = GRM_ROW_LAST,
  parameter logic [7:0] COL_LAST   = GRM_COL_LAST,
  parameter int         FIFO_DEPTH = GRM_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  localparam int RAM_WORDS = (int'(ROW_LAST) + 1) * 256;

  typedef struct packed {
    logic          dir_inc;
    logic          vertical_step_sel;
    grm_op_type    logic_op_sel;
    logic          bus_wide;
    logic [15:0]   write_bit_mask;
    logic [15:0]   compare_value;
    logic [15:0]   addr_counter;
    logic [15:0]   read_latch;
    logic [15:0]   host_word;
    logic [15:0]   skip_count;
    grm_state_type st;
    logic [31:0]   rdata;
  } grm_regs_type;

  grm_regs_type regs_reg;
  grm_regs_type regs_next;
  logic [15:0]  display_ram [0:RAM_WORDS-1];

  logic         fifo_in_valid;
  logic         fifo_in_ready;
  logic         fifo_out_valid;
  logic         fifo_out_ready;
  logic [15:0]  fifo_out_data;
  logic         busy;
  logic         mapped;
  logic         setup;
  logic         access;
  logic         do_write;
  logic [15:0]  result;
  logic [15:0]  merged;
  grm_op_type   op_eff;

  // Byte-wise equality of two words
  function automatic logic grm_byte_match(input logic [15:0] a, input logic [15:0] b);
    grm_byte_match = (a[15:8] == b[15:8]) && (a[7:0] == b[7:0]);
  endfunction : grm_byte_match

  // Address step with edge wrap
  function automatic logic [15:0] grm_next_addr(input logic [15:0] a, input logic vert, input logic inc,
                                                input logic [7:0] rl, input logic [7:0] cl);
    logic [7:0] row;
    logic [7:0] col;
    row = a[15:8];
    col = a[7:0];
    if (vert) begin
      if (row >= rl) begin
        row = 8'h00;
        if (inc) begin
          col = (col >= cl) ? 8'h00 : col + 8'h01;
        end else begin
          col = (col == 8'h00) ? cl : col - 8'h01;
        end
      end else begin
        row = row + 8'h01;
      end
    end else begin
      if (inc ? (col >= cl) : (col == 8'h00)) begin
        col = inc ? 8'h00 : cl;
        row = (row >= rl) ? 8'h00 : row + 8'h01;
      end else begin
        col = inc ? col + 8'h01 : col - 8'h01;
      end
    end
    grm_next_addr = {row, col};
  endfunction : grm_next_addr

  grm_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (pwdata[15:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Bus decode
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign busy   = (regs_reg.st != GRM_ST_IDLE) || fifo_out_valid;
  assign mapped = (paddr == GRM_CTRL_OFS) || (paddr == GRM_MASK_OFS) || (paddr == GRM_CMP_OFS) ||
                  (paddr == GRM_ADDR_OFS) || (paddr == GRM_DATA_OFS) || (paddr == GRM_STAT_OFS) ||
                  (paddr == GRM_LATCH_OFS);

  // Pixel writes stall on a full buffer, setting writes until the engine drains
  always_comb begin
    pready = 1'b1;
    if (access && pwrite && mapped) begin
      if (paddr == GRM_DATA_OFS) begin
        pready = fifo_in_ready;
      end else if (paddr != GRM_STAT_OFS && paddr != GRM_LATCH_OFS) begin
        pready = !busy;
      end
    end
  end

  assign pslverr        = access && !mapped;
  assign prdata         = regs_reg.rdata;
  assign fifo_in_valid  = access && pwrite && (paddr == GRM_DATA_OFS);
  assign fifo_out_ready = (regs_reg.st == GRM_ST_IDLE);

  // Operation and merge
  always_comb begin
    op_eff   = regs_reg.bus_wide ? GRM_OP_REPLACE : regs_reg.logic_op_sel;
    result   = regs_reg.host_word;
    do_write = 1'b1;
    unique case (op_eff)
      GRM_OP_REPLACE: begin
        result = regs_reg.host_word;
      end
      GRM_OP_OR: begin
        result = regs_reg.read_latch | regs_reg.host_word;
      end
      GRM_OP_AND: begin
        result = regs_reg.read_latch & regs_reg.host_word;
      end
      GRM_OP_XOR: begin
        result = regs_reg.read_latch ^ regs_reg.host_word;
      end
      GRM_OP_RD_MATCH: begin
        do_write = grm_byte_match(regs_reg.read_latch, regs_reg.compare_value);
      end
      GRM_OP_RD_MISMATCH: begin
        do_write = !grm_byte_match(regs_reg.read_latch, regs_reg.compare_value);
      end
      GRM_OP_WR_MATCH: begin
        do_write = grm_byte_match(regs_reg.host_word, regs_reg.compare_value);
      end
      GRM_OP_WR_MISMATCH: begin
        do_write = !grm_byte_match(regs_reg.host_word, regs_reg.compare_value);
      end
    endcase
    merged = (result & ~regs_reg.write_bit_mask) | (regs_reg.read_latch & regs_reg.write_bit_mask);
  end

  always_comb begin
    regs_next = regs_reg;
    // Read data captured in the setup phase
    if (setup && !pwrite) begin
      unique case (paddr)
        GRM_CTRL_OFS: begin
          regs_next.rdata = {26'h0000000, regs_reg.bus_wide, regs_reg.logic_op_sel,
                             regs_reg.vertical_step_sel, regs_reg.dir_inc};
        end
        GRM_MASK_OFS: begin
          regs_next.rdata = {16'h0000, regs_reg.write_bit_mask};
        end
        GRM_CMP_OFS: begin
          regs_next.rdata = {16'h0000, regs_reg.compare_value};
        end
        GRM_ADDR_OFS: begin
          regs_next.rdata = {16'h0000, regs_reg.addr_counter};
        end
        GRM_STAT_OFS: begin
          regs_next.rdata = {regs_reg.skip_count, 14'h0000, fifo_out_valid, busy};
        end
        GRM_LATCH_OFS: begin
          regs_next.rdata = {16'h0000, regs_reg.read_latch};
        end
        default: begin
          regs_next.rdata = 32'h00000000;
        end
      endcase
    end
    // Register writes take effect at the completing edge
    if (access && pwrite && pready) begin
      unique case (paddr)
        GRM_CTRL_OFS: begin
          regs_next.dir_inc           = pwdata[GRM_CTRL_INC];
          regs_next.vertical_step_sel = pwdata[GRM_CTRL_VERT];
          regs_next.logic_op_sel      = grm_op_type'(pwdata[GRM_CTRL_OP +: 3]);
          regs_next.bus_wide          = pwdata[GRM_CTRL_WIDE];
        end
        GRM_MASK_OFS: begin
          regs_next.write_bit_mask = pwdata[15:0];
        end
        GRM_CMP_OFS: begin
          regs_next.compare_value = pwdata[15:0];
        end
        GRM_ADDR_OFS: begin
          regs_next.addr_counter = pwdata[15:0];
        end
        default: begin
        end
      endcase
    end
    // Read-modify-write engine
    unique case (regs_reg.st)
      GRM_ST_IDLE: begin
        if (fifo_out_valid) begin
          regs_next.host_word = fifo_out_data;
          regs_next.st        = GRM_ST_READ;
        end
      end
      GRM_ST_READ: begin
        regs_next.read_latch = display_ram[regs_reg.addr_counter];
        regs_next.st         = GRM_ST_WRITE;
      end
      GRM_ST_WRITE: begin
        if (!do_write) begin
          regs_next.skip_count = regs_reg.skip_count + 16'h0001;
        end
        regs_next.addr_counter = grm_next_addr(regs_reg.addr_counter, regs_reg.vertical_step_sel,
                                               regs_reg.dir_inc, ROW_LAST, COL_LAST);
        regs_next.st           = GRM_ST_IDLE;
      end
      default: begin
        regs_next.st = GRM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regs_reg                   <= '0;
      regs_reg.dir_inc           <= GRM_INC_RST;
      regs_reg.logic_op_sel      <= GRM_OP_REPLACE;
      regs_reg.write_bit_mask    <= GRM_MASK_RST;
      regs_reg.compare_value     <= GRM_CMP_RST;
      regs_reg.addr_counter      <= GRM_ADDR_RST;
      regs_reg.st                <= GRM_ST_IDLE;
    end else begin
      regs_reg <= regs_next;
    end
  end

  // Masked write-back, skipped when the compare fails
  always_ff @(posedge pclk) begin
    if (regs_reg.st == GRM_ST_WRITE && do_write) begin
      display_ram[regs_reg.addr_counter] <= merged;
    end
  end

endmodule : grm_display_ram_rmw

// file: grm_display_ram_rmw_chk.sv
`timescale 1ns/1ns
module grm_display_ram_rmw_chk
  import grm_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic mapped;
  assign acc = psel && penable;
  assign mapped = paddr <= GRM_LATCH_OFS && paddr[1:0] == 2'b00;
  sequence rd_done;
    acc && !pwrite && pready;
  endsequence
  a_err_unmapped: assert property (acc && !mapped |-> pslverr && pready) else $error("unmapped access not flagged");
  a_err_mapped: assert property (acc && mapped |-> !pslverr) else $error("error on mapped access");
  a_err_outside: assert property (!acc |-> !pslverr) else $error("error outside access");
  a_read_nowait: assert property (acc && !pwrite |-> pready) else $error("read stalled");
  a_data_hidden: assert property (acc && !pwrite && paddr == GRM_DATA_OFS |-> prdata == 32'h0) else $error("data read");
  a_rd_hold: assert property (rd_done ##1 !psel |-> $stable(prdata)) else $error("read data moved");
  a_ro_ready: assert property (acc && pwrite && paddr >= GRM_STAT_OFS |-> pready) else $error("read-only write stalled");
  a_wait_bound: assert property (acc && !pready |-> ##[1:60] pready) else $error("stall too long");
  a_stat_zero: assert property (acc && !pwrite && paddr == GRM_STAT_OFS |-> prdata[15:2] == 14'h0) else $error("status bits");
endmodule : grm_display_ram_rmw_chk

// file: grm_host.sv
`timescale 1ns/1ns
module grm_host (
  // Clock
  input  wire logic        pclk,
  // APB request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // APB answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One transfer, begun just after a rising edge; held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
  endtask : xfer
  // Release the bus; stale write data is scrambled
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
    @(posedge pclk);
  endtask : idle
endmodule : grm_host

// file: tb_grm_display_ram_rmw.sv
`timescale 1ns/1ns
module tb_grm_display_ram_rmw;
  import grm_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, e, hit;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] r;
  int          miscompares = 0;
  int          total_checks = 0;
  int          skips = 0;
  logic [31:0] rst_val [6] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [5:0]  wc [5] = '{6'h01, 6'h00, 6'h03, 6'h02, 6'h00};
  logic [15:0] wa [5] = '{16'h0083, 16'h0400, 16'hAF00, 16'hAF05, 16'h0410};
  logic [15:0] wx [5] = '{16'h0100, 16'h0583, 16'h0001, 16'h0004, 16'h040F};
  always #5 pclk = ~pclk;
  grm_display_ram_rmw DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  grm_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
    host.idle();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q, e);
    host.idle();
  endtask : rd
  // Mode, mask and address, then one pixel word
  task automatic px(input logic [5:0] c, input logic [15:0] m, input logic [15:0] a, input logic [15:0] d);
    wr(GRM_CTRL_OFS, {26'h0, c});
    wr(GRM_MASK_OFS, {16'h0, m});
    wr(GRM_ADDR_OFS, {16'h0, a});
    wr(GRM_DATA_OFS, {16'h0, d});
  endtask : px
  // Stored word via the read latch; full mask keeps it intact
  task automatic peek(input logic [15:0] a, input logic [15:0] x);
    px(6'h01, 16'hFFFF, a, 16'h0000);
    wr(GRM_MASK_OFS, 32'h0);
    rd(GRM_LATCH_OFS);
    chk("latch", {16'h0, q[15:0]}, {16'h0, x});
  endtask : peek
  // Settings write waits for the engine, then the counter is read
  task automatic addr_is(input logic [15:0] x);
    wr(GRM_MASK_OFS, 32'h0);
    rd(GRM_ADDR_OFS);
    chk("addr", q, {16'h0, x});
  endtask : addr_is
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4));
      chk("reset", q, rst_val[i]);
    end
    // Logical ops in vertical mode, then the wide-bus forced replace
    for (int op = 0; op < 5; op++) begin
      px(6'h01, 16'h0000, 16'h0005, 16'h5A3C);
      px(op == 4 ? 6'h2F : {1'b0, op[2:0], 2'b11}, 16'h00FF, 16'h0005, 16'h0FF0);
      addr_is(16'h0105);
      r = (op == 1) ? (16'h5A3C | 16'h0FF0) : (op == 2) ? (16'h5A3C & 16'h0FF0) :
          (op == 3) ? (16'h5A3C ^ 16'h0FF0) : 16'h0FF0;
      peek(16'h0005, (r & 16'hFF00) | (16'h5A3C & 16'h00FF));
    end
    // Compare codes, match and low-byte mismatch, horizontal and vertical increment steps
    for (int k = 0; k < 8; k++) begin
      px(6'h01, 16'h0000, 16'h0A10, 16'h2860);
      wr(GRM_CMP_OFS, k[1] ? 32'h2861 : 32'h2860);
      px({3'b010, k[0], k[2], 1'b1}, 16'h0000, 16'h0A10, 16'h1234);
      addr_is(k[2] ? 16'h0B10 : 16'h0A11);
      hit = (k[0] == k[1]);
      skips += int'(!hit);
      rd(GRM_STAT_OFS);
      chk("skips", {16'h0, q[31:16]}, 32'(skips));
      peek(16'h0A10, hit ? 16'h1234 : 16'h2860);
    end
    // Host-data compare codes with a partial mask
    for (int k = 0; k < 4; k++) begin
      px(6'h01, 16'h0000, 16'h0300, 16'h2860);
      wr(GRM_CMP_OFS, 32'h1234);
      px({3'b011, k[0], 2'b01}, 16'h00FF, 16'h0300, k[1] ? 16'h1235 : 16'h1234);
      addr_is(16'h0301);
      hit = (k[0] == k[1]);
      skips += int'(!hit);
      rd(GRM_STAT_OFS);
      chk("skips", {16'h0, q[31:16]}, 32'(skips));
      peek(16'h0300, hit ? 16'h1260 : 16'h2860);
    end
    // Edge wraps of the address counter, then one plain decrement step
    for (int i = 0; i < 5; i++) begin
      px(wc[i], 16'h0000, wa[i], 16'h1111);
      addr_is(wx[i]);
    end
    // Back-to-back pushes fill the buffer and stall the bus
    px(6'h01, 16'h0000, 16'h0200, 16'hAAAA);
    for (int i = 0; i < 16; i++) host.xfer(1'b1, GRM_DATA_OFS, 32'(i), q, e);
    host.idle();
    addr_is(16'h0211);
    peek(16'h0210, 16'h000F);
    rd(8'h1C);
    chk("slverr", {31'h0, e}, 32'h1);
    chk("unmapped", q, 32'h0);
    conclude();
  end
endmodule : tb_grm_display_ram_rmw

bind grm_display_ram_rmw grm_display_ram_rmw_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
